// *** apc_pkg.sv ***
package apc_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] PORT_OFF = 8'h08;
    localparam logic [7:0] LINK_OFF = 8'h0C;
    // phy_interface_config fields
    localparam int TX_SEL_LSB = 29;
    localparam int TX_ODD_BIT = 28;
    localparam int TX_SIZE_BIT = 27;
    localparam int CELL52_BIT = 18;
    localparam int HEC_DIS_BIT = 17;
    localparam int TX_FULL_BIT = 16;
    localparam int RX_SEL_LSB = 13;
    localparam int RX_CHK_BIT = 12;
    localparam int RX_ODD_BIT = 11;
    localparam int RX_SIZE_BIT = 10;
    localparam int RX_FULL_BIT = 9;
    localparam logic [31:0] CFG_RESET = 32'h1001_0A00;
    localparam logic [31:0] CFG_MASK = 32'hF807_FE00;
    // status fields
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_CNT_LSB = 8;
    localparam int STAT_TXU_BIT = 16;
    localparam int STAT_RXA_BIT = 17;
    // port register fields and link control HEC byte
    localparam int TX_PORT_LSB = 0;
    localparam int RX_PORT_LSB = 8;
    localparam logic [31:0] PORT_RESET = 32'h0000_0000;
    localparam int LINK_HEC_LSB = 0;
    localparam logic [31:0] LINK_RESET = 32'h0000_0000;
    // phy device select codes
    localparam logic [2:0] SEL_FRAME = 3'h1;
    localparam logic [2:0] SEL_CELL = 3'h3;
    localparam logic [2:0] SEL_INT = 3'h5;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** apc_parity.sv ***
`timescale 1ns/1ps
module apc_parity
    import apc_pkg::*;
#(
    parameter int LANES = 2
) (
    // word in
    input wire logic [LANES*8-1:0] data,
    input wire logic oddSel,
    // parities out
    output logic [LANES-1:0] laneParity,
    output logic fullParity
);
    // xor of covered bits, inverted for odd
    for (genvar i = 0; i < LANES; i++) begin : gLane
        assign laneParity[i] = (^data[i*8 +: 8]) ^ oddSel;
    end
    assign fullParity = (^data) ^ oddSel;
endmodule

// *** apc_config_top.sv ***
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Tx options apply only for UTOPIA cell device
// - 52-byte mode sends cells without HEC
// - HEC disable sends zero, else link HEC
// - 52-byte mode overrides the HEC disable bit
// - full-width tx parity: one bit, reset one
// - otherwise one tx parity bit per byte
// - decode 3-bit rx device select codes
// - port address all ones: select ignored
// - rx parity checking enable, off at reset
// - rx internal framer: upper tx parity invalid
// - tx internal framer: upper rx parity invalid
// - rx parity even at 0, odd at reset
// - path size bit: 16-bit at 0, 8-bit at 1
// - mixed framer: size bit assigns lines 15-13
// - full-width rx parity checked against line 1
// - 8-bit rx parity checked against line 1
// - rx full-width bit ignored for frame PHY
// - tx device select uses same encoding
module apc_config_top
    import apc_pkg::*;
#(
    parameter int PORT_W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transmit cell stream from internal logic
    input wire logic [15:0] txData,
    input wire logic txValid,
    input wire logic txHecItem,
    input wire logic [2:0] hdlcTxLines,
    // transmit phy pins
    output logic [15:0] txPhyDataLines,
    output logic txPhyValid,
    output logic [1:0] txPhyParity,
    // receive phy pins
    input wire logic [15:0] rxPhyData,
    input wire logic rxPhyValid,
    input wire logic [1:0] rxPhyParityLines,
    // receive check result
    output logic rxParityErr
);
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] port;
        logic [31:0] linkCtl;
        logic statErr;
        logic [7:0] errCnt;
        logic awRdy;
        logic wRdy;
        logic awHeld;
        logic wHeld;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [18:0] rxSync1;
        logic [18:0] rxSync2;
        logic [15:0] txOut;
        logic txOutValid;
        logic [1:0] txPar;
        logic rxErr;
    } apc_state_t;

    apc_state_t s_q;
    apc_state_t s_d;

    logic [2:0] txSel;
    logic [2:0] rxSel;
    logic txUsed;
    logic rxUsed;
    logic txUtopia;
    logic txInternal;
    logic rxInternal;
    logic rxExternal;
    logic checkActive;
    logic [15:0] txWord;
    logic [1:0] txLanePar;
    logic txFullPar;
    logic [1:0] rxLanePar;
    logic rxFullPar;
    logic rxMismatch;

    assign txSel = s_q.cfg[TX_SEL_LSB +: 3];
    assign rxSel = s_q.cfg[RX_SEL_LSB +: 3];
    // an all-ones port address marks the configuration unused
    assign txUsed = s_q.port[TX_PORT_LSB +: PORT_W] != '1;
    assign rxUsed = s_q.port[RX_PORT_LSB +: PORT_W] != '1;
    assign txUtopia = txUsed && txSel == SEL_CELL;
    assign txInternal = txUsed && txSel == SEL_INT;
    assign rxInternal = rxUsed && rxSel == SEL_INT;
    assign rxExternal = rxUsed && (rxSel == SEL_FRAME || rxSel == SEL_CELL);
    // reserved codes and the internal framer leave the rx pins unchecked
    assign checkActive = s_q.cfg[RX_CHK_BIT] && rxExternal && s_q.rxSync2[18];

    always_comb begin
        txWord = txData;
        if (txHecItem) begin
            if (txUtopia && s_q.cfg[HEC_DIS_BIT]) begin
                txWord[7:0] = 8'h00;
            end else begin
                txWord[7:0] = s_q.linkCtl[LINK_HEC_LSB +: 8];
            end
        end
        // mixed framer: lines 15-13 shared with rx hdlc controller
        if (rxInternal && !txInternal && !s_q.cfg[TX_SIZE_BIT]) begin
            txWord[15:13] = hdlcTxLines;
        end
    end

    apc_parity #(.LANES(2)) uTxPar (
        .data(txWord),
        .oddSel(s_q.cfg[TX_ODD_BIT]),
        .laneParity(txLanePar),
        .fullParity(txFullPar)
    );

    apc_parity #(.LANES(2)) uRxPar (
        .data(s_q.rxSync2[15:0]),
        .oddSel(s_q.cfg[RX_ODD_BIT]),
        .laneParity(rxLanePar),
        .fullParity(rxFullPar)
    );

    always_comb begin
        if (s_q.cfg[RX_SIZE_BIT]) begin
            rxMismatch = rxLanePar[0] != s_q.rxSync2[17];
        end else if (s_q.cfg[RX_FULL_BIT] && rxSel != SEL_FRAME) begin
            rxMismatch = rxFullPar != s_q.rxSync2[17];
        end else begin
            rxMismatch = rxLanePar[0] != s_q.rxSync2[16];
            if (!txInternal && rxLanePar[1] != s_q.rxSync2[17]) begin
                rxMismatch = 1'b1;
            end
        end
    end

    always_comb begin
        logic [31:0] merged;
        logic [31:0] rd;
        merged = '0;
        rd = '0;
        s_d = s_q;
        // write channel: address and data in either order
        if (s_axi_awvalid && s_q.awRdy) begin
            s_d.awHeld = 1'b1;
            s_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wRdy) begin
            s_d.wHeld = 1'b1;
            s_d.wData = s_axi_wdata;
            s_d.wStrb = s_axi_wstrb;
        end
        if (s_q.bValid && s_axi_bready) begin
            s_d.bValid = 1'b0;
        end
        if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
            s_d.awHeld = 1'b0;
            s_d.wHeld = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = RESP_OKAY;
            for (int i = 0; i < 4; i++) begin
                merged[i*8 +: 8] = s_q.wStrb[i] ? s_q.wData[i*8 +: 8] : 8'h00;
            end
            case (s_q.awAddr)
                CFG_OFF: begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_q.wStrb[i]) begin
                            s_d.cfg[i*8 +: 8] = merged[i*8 +: 8] & CFG_MASK[i*8 +: 8];
                        end
                    end
                end
                PORT_OFF: begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_q.wStrb[i]) begin
                            s_d.port[i*8 +: 8] = merged[i*8 +: 8];
                        end
                    end
                end
                LINK_OFF: begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_q.wStrb[i]) begin
                            s_d.linkCtl[i*8 +: 8] = merged[i*8 +: 8];
                        end
                    end
                end
                STAT_OFF: begin
                    // write one to clear flag and count
                    if (merged[STAT_ERR_BIT]) begin
                        s_d.statErr = 1'b0;
                        s_d.errCnt = '0;
                    end
                end
                default: begin
                    s_d.bResp = RESP_SLVERR;
                end
            endcase
        end
        // read channel
        if (s_q.rValid && s_axi_rready) begin
            s_d.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arRdy) begin
            s_d.rValid = 1'b1;
            s_d.rResp = RESP_OKAY;
            case (s_axi_araddr)
                CFG_OFF: rd = s_q.cfg;
                PORT_OFF: rd = s_q.port;
                LINK_OFF: rd = s_q.linkCtl;
                STAT_OFF: begin
                    rd[STAT_ERR_BIT] = s_q.statErr;
                    rd[STAT_CNT_LSB +: 8] = s_q.errCnt;
                    rd[STAT_TXU_BIT] = txUtopia;
                    rd[STAT_RXA_BIT] = s_q.cfg[RX_CHK_BIT] && rxExternal;
                end
                default: s_d.rResp = RESP_SLVERR;
            endcase
            s_d.rData = rd;
        end
        s_d.awRdy = !s_d.awHeld && !s_d.bValid;
        s_d.wRdy = !s_d.wHeld && !s_d.bValid;
        s_d.arRdy = !s_d.rValid;
        // rx pins cross into clk through two flops
        s_d.rxSync1 = {rxPhyValid, rxPhyParityLines, rxPhyData};
        s_d.rxSync2 = s_q.rxSync1;
        s_d.rxErr = checkActive && rxMismatch;
        // set wins over a clear in the same cycle
        if (s_d.rxErr) begin
            s_d.statErr = 1'b1;
            if (s_d.errCnt != 8'hFF) begin
                s_d.errCnt = s_d.errCnt + 8'h01;
            end
        end
        // transmit: hec item dropped in 52-byte mode
        s_d.txOutValid = txValid && !(txHecItem && txUtopia && s_q.cfg[CELL52_BIT]);
        s_d.txOut = txWord;
        if (s_q.cfg[TX_SIZE_BIT]) begin
            s_d.txPar = {1'b0, txLanePar[0]};
        end else if (txUtopia && s_q.cfg[TX_FULL_BIT]) begin
            s_d.txPar = {1'b0, txFullPar};
        end else begin
            s_d.txPar = {txLanePar[1] && !rxInternal, txLanePar[0]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '{cfg: CFG_RESET, port: PORT_RESET, linkCtl: LINK_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awRdy;
    assign s_axi_wready = s_q.wRdy;
    assign s_axi_bvalid = s_q.bValid;
    assign s_axi_bresp = s_q.bResp;
    assign s_axi_arready = s_q.arRdy;
    assign s_axi_rvalid = s_q.rValid;
    assign s_axi_rdata = s_q.rData;
    assign s_axi_rresp = s_q.rResp;
    assign txPhyDataLines = s_q.txOut;
    assign txPhyValid = s_q.txOutValid;
    assign txPhyParity = s_q.txPar;
    assign rxParityErr = s_q.rxErr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    cell52_drop_a: assert property (
        txValid && txHecItem && txUtopia && s_q.cfg[CELL52_BIT] |=> !txPhyValid)
        else $error("hec item sent in 52-byte mode");
    hec_zero_a: assert property (
        txValid && txHecItem && txUtopia && s_q.cfg[HEC_DIS_BIT] && !s_q.cfg[CELL52_BIT]
        |=> txPhyValid && txPhyDataLines[7:0] == 8'h00)
        else $error("hec byte not zero when disabled");
    opts_ignored_a: assert property (
        txValid && txHecItem && !txUtopia
        |=> txPhyValid && txPhyDataLines[7:0] == $past(s_q.linkCtl[7:0]))
        else $error("tx options applied for non-utopia device");
    full_parity_a: assert property (
        txUtopia && s_q.cfg[TX_FULL_BIT] && !s_q.cfg[TX_SIZE_BIT]
        |=> txPhyParity == {1'b0, (^txPhyDataLines) ^ $past(s_q.cfg[TX_ODD_BIT])})
        else $error("full-width tx parity wrong");
    byte_parity_a: assert property (
        !s_q.cfg[TX_FULL_BIT] && !s_q.cfg[TX_SIZE_BIT] && !rxInternal
        |=> txPhyParity[1] == ((^txPhyDataLines[15:8]) ^ $past(s_q.cfg[TX_ODD_BIT])))
        else $error("upper byte tx parity wrong");
    upper_invalid_a: assert property (
        rxInternal |=> !txPhyParity[1])
        else $error("upper tx parity driven with internal rx framer");
    hdlc_lines_a: assert property (
        rxInternal && !txInternal && !s_q.cfg[TX_SIZE_BIT]
        |=> txPhyDataLines[15:13] == $past(hdlcTxLines))
        else $error("lines 15-13 not given to hdlc");
    check_off_a: assert property (
        !s_q.cfg[RX_CHK_BIT] |=> !rxParityErr)
        else $error("parity error while checking disabled");
    sticky_err_a: assert property (
        rxParityErr |-> s_q.statErr)
        else $error("error flag not set");
    rx_full_a: assert property (
        checkActive && !s_q.cfg[RX_SIZE_BIT] && s_q.cfg[RX_FULL_BIT] && rxSel == SEL_CELL
        && ((^s_q.rxSync2[15:0]) ^ s_q.cfg[RX_ODD_BIT]) != s_q.rxSync2[17] |=> rxParityErr)
        else $error("full-width rx parity error missed");
    unused_rx_a: assert property (
        !rxUsed |=> !rxParityErr)
        else $error("unused rx configuration checked");

    drop_seen_c: cover property (txValid && txHecItem && txUtopia && s_q.cfg[CELL52_BIT]);
    err_seen_c: cover property (rxParityErr);
    wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
    mixed_seen_c: cover property (rxInternal && !txInternal && txValid);
endmodule

// *** apc_phy_model.sv ***
`timescale 1ns/1ps
module apc_phy_model (
    // clock
    input wire logic clk,
    // transmit pins from the block
    input wire logic [15:0] txPhyDataLines,
    input wire logic txPhyValid,
    input wire logic [1:0] txPhyParity,
    // receive pins to the block
    output logic [15:0] rxPhyData,
    output logic rxPhyValid,
    output logic [1:0] rxPhyParityLines
);
    int txCount = 0;
    logic [15:0] txWord = 16'h0000;
    logic [1:0] txPar = 2'h0;

    initial begin
        rxPhyData = 16'h0000;
        rxPhyValid = 1'b0;
        rxPhyParityLines = 2'h0;
    end

    always @(posedge clk) begin
        if (txPhyValid === 1'b1) begin
            txCount <= txCount + 1;
            txWord <= txPhyDataLines;
            txPar <= txPhyParity;
        end
    end

    // one word for one cycle; caller supplies the parity lines, right or wrong
    task automatic sendRx(input logic [15:0] w, input logic [1:0] p);
        rxPhyData <= w;
        rxPhyParityLines <= p;
        rxPhyValid <= 1'b1;
        @(posedge clk);
        // released lines show the inverse so a stale copy cannot pass
        rxPhyData <= ~w;
        rxPhyParityLines <= ~p;
        rxPhyValid <= 1'b0;
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
    import apc_pkg::*;
;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0000_0000;
    logic [3:0] wStrb = 4'hF;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, txPhyValid, rxPhyValid, rxParityErr;
    logic [1:0] bResp, rResp, txPhyParity, rxPhyParityLines;
    logic [31:0] rData;
    logic [15:0] txData = 16'h0000, txPhyDataLines, rxPhyData;
    logic txValid = 1'b0, txHecItem = 1'b0;
    logic [2:0] hdlcTxLines = 3'h2;
    int errTotal = 0, checks = 0, cycles = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    apc_config_top #(.PORT_W(5)) dut_u (
        .clk(clk), .sys_rst(sysRst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .txData(txData), .txValid(txValid), .txHecItem(txHecItem), .hdlcTxLines(hdlcTxLines),
        .txPhyDataLines(txPhyDataLines), .txPhyValid(txPhyValid), .txPhyParity(txPhyParity),
        .rxPhyData(rxPhyData), .rxPhyValid(rxPhyValid), .rxPhyParityLines(rxPhyParityLines),
        .rxParityErr(rxParityErr)
    );

    apc_phy_model phy_u (
        .clk(clk), .txPhyDataLines(txPhyDataLines), .txPhyValid(txPhyValid),
        .txPhyParity(txPhyParity), .rxPhyData(rxPhyData), .rxPhyValid(rxPhyValid),
        .rxPhyParityLines(rxPhyParityLines)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic stopTest();
        $display("errors %0d checks %0d", errTotal, checks);
        if (errTotal == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errTotal++;
            stopTest();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        r = 2'h0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awReady === 1'b1) awValid <= 1'b0;
            if (wReady === 1'b1) wValid <= 1'b0;
            if (bValid === 1'b1) begin
                r = bResp;
                bReady <= 1'b0;
                done = 1'b1;
            end
        end
        // idle edge so a following call never lowers and raises bready in one step
        @(posedge clk);
    endtask

    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        d = 32'h0000_0000;
        r = 2'h0;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arReady === 1'b1) arValid <= 1'b0;
            if (rValid === 1'b1) begin
                d = rData;
                r = rResp;
                rReady <= 1'b0;
                done = 1'b1;
            end
        end
        // idle edge so a following call never lowers and raises rready in one step
        @(posedge clk);
    endtask

    task automatic txCase(input logic [15:0] w, input logic h, input int n, input logic [15:0] ew);
        int n0;
        n0 = phy_u.txCount;
        txData <= w;
        txHecItem <= h;
        txValid <= 1'b1;
        @(posedge clk);
        txValid <= 1'b0;
        txHecItem <= 1'b0;
        repeat (2) @(posedge clk);
        chk(phy_u.txCount - n0, n);
        if (n == 1) chk(32'(phy_u.txWord), 32'(ew));
    endtask

    // word a5c1: upper byte even weight, lower byte odd weight
    task automatic rxCase(input logic [31:0] c, input logic [1:0] p, input int e);
        int n;
        n = 0;
        axiWr(CFG_OFF, c, rs);
        repeat (2) @(posedge clk);
        phy_u.sendRx(16'hA5C1, p);
        repeat (6) begin
            @(posedge clk);
            if (rxParityErr === 1'b1) n++;
        end
        chk(n, e);
    endtask

    task automatic regTest();
        axiRd(CFG_OFF, rd, rs);
        chk(rd, CFG_RESET);
        axiWr(CFG_OFF, 32'hFFFF_FFFF, rs);
        axiRd(CFG_OFF, rd, rs);
        chk(rd, CFG_MASK);
        axiRd(8'h10, rd, rs);
        chk(32'(rs), 32'(RESP_SLVERR));
        axiWr(8'h10, 32'h0000_0001, rs);
        chk(32'(rs), 32'(RESP_SLVERR));
    endtask

    task automatic hecTest();
        axiWr(LINK_OFF, 32'h0000_005A, rs);
        axiWr(CFG_OFF, 32'h7003_0000, rs);
        txCase(16'h1234, 1'b1, 1, 16'h1200);
        chk(32'(phy_u.txPar), 32'h0000_0001);
        axiWr(CFG_OFF, 32'h7001_0000, rs);
        txCase(16'h1234, 1'b1, 1, 16'h125A);
        axiWr(CFG_OFF, 32'h7007_0000, rs);
        txCase(16'h1234, 1'b1, 0, 16'h0000);
        txCase(16'hA5C1, 1'b0, 1, 16'hA5C1);
        axiWr(CFG_OFF, 32'h3007_0000, rs);
        txCase(16'h1234, 1'b1, 1, 16'h125A);
    endtask

    task automatic txParTest();
        axiWr(CFG_OFF, 32'h7000_0000, rs);
        txCase(16'hA5C1, 1'b0, 1, 16'hA5C1);
        chk(32'(phy_u.txPar), 32'h0000_0002);
        axiWr(CFG_OFF, 32'h6000_0000, rs);
        txCase(16'hA5C1, 1'b0, 1, 16'hA5C1);
        chk(32'(phy_u.txPar), 32'h0000_0001);
        // odd full-width gives 00 where per-byte would give 10
        axiWr(CFG_OFF, 32'h7001_0000, rs);
        txCase(16'hA5C1, 1'b0, 1, 16'hA5C1);
        chk(32'(phy_u.txPar), 32'h0000_0000);
    endtask

    // hdlc lines replace 15-13 on a 16-bit external tx, not on an 8-bit one
    task automatic laneTest();
        axiWr(CFG_OFF, 32'h7001_A000, rs);
        txCase(16'hA5C1, 1'b0, 1, 16'h45C1);
        axiWr(CFG_OFF, 32'h7801_A000, rs);
        txCase(16'hA5C1, 1'b0, 1, 16'hA5C1);
    endtask

    task automatic rxTest();
        rxCase(32'h7001_7800, 2'b10, 0);
        rxCase(32'h7001_7800, 2'b11, 1);
        rxCase(32'h7001_7800, 2'b00, 1);
        rxCase(32'h7001_7000, 2'b01, 0);
        rxCase(32'h7001_7000, 2'b10, 1);
        rxCase(32'h7001_6800, 2'b11, 0);
        rxCase(32'h7001_7A00, 2'b01, 0);
        rxCase(32'h7001_7A00, 2'b10, 1);
        rxCase(32'h7001_7C00, 2'b01, 0);
        rxCase(32'h7001_7C00, 2'b10, 1);
        rxCase(32'h7001_3A00, 2'b10, 0);
        rxCase(32'hB001_7800, 2'b00, 0);
        axiWr(PORT_OFF, 32'h0000_1F00, rs);
        rxCase(32'h7001_7800, 2'b11, 0);
        axiWr(PORT_OFF, 32'h0000_0000, rs);
        // five failing words so far: sticky flag, count 5, utopia tx and rx check active
        axiRd(STAT_OFF, rd, rs);
        chk(rd, 32'h0003_0501);
        axiWr(STAT_OFF, 32'h0000_0001, rs);
        axiRd(STAT_OFF, rd, rs);
        chk(rd, 32'h0003_0000);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        regTest();
        hecTest();
        txParTest();
        laneTest();
        rxTest();
        stopTest();
    end
endmodule
